// >>> bench/pfm_pin_model.sv
// Purpose: far-side pin model, resolves pins against external levels
// Assumes: oe_n low means the block drives the pin
// Notes:   undriven pins show the external pattern, port 4 pins its inverse; never a held value
`timescale 1ns/1ps
module pfm_pin_model (
    // block side
    input  wire logic [7:0] ctl_pin_out,
    input  wire logic [7:0] ctl_pin_oe_n,
    input  wire logic [7:0] port1_pin_out,
    input  wire logic [7:0] port1_pin_oe_n,
    input  wire logic [7:0] portb_pin_out,
    input  wire logic [7:0] portb_pin_oe_n,
    // external levels
    input  wire logic [7:0] ext_pat,
    // resolved pins
    output logic      [7:0] ctl_pin_in,
    output logic      [7:0] port1_pin_in,
    output logic      [7:0] portb_pin_in,
    output logic      [7:0] port4_pin_in
);
    assign port4_pin_in = ~ext_pat;
    assign ctl_pin_in   = (ctl_pin_out & ~ctl_pin_oe_n) | (ext_pat & ctl_pin_oe_n);
    assign port1_pin_in = (port1_pin_out & ~port1_pin_oe_n) | (ext_pat & port1_pin_oe_n);
    assign portb_pin_in = (portb_pin_out & ~portb_pin_oe_n) | (ext_pat & portb_pin_oe_n);
endmodule // pfm_pin_model

// >>> bench/tb_port_function_mux_by_mode.sv
// Purpose: scenario bench for the mode-dependent port function mux
// Assumes: outputs registered; routed inputs settle three cycles after pins
// Notes:   port B address use in modes 4-6 checked at the pins, in mode 4 also on readback
`timescale 1ns/1ps
module tb_port_function_mux_by_mode;
    logic       ref_clk, rst_n, bus_16bit, bus_release_enable, sys_clk_en, chip_select_0;
    logic       clk_dir_wr, clk_dir_val, cs0_dir_wr, cs0_dir_val, address_strobe, read_strobe;
    logic       high_byte_write_strobe, low_byte_write_strobe, cs0_pin_out, cs0_pin_oe_n;
    logic       ext_int_line_0, ext_int_line_1, ext_int_line_2, ext_int_line_3;
    logic       conv_trigger_in, bus_request_in, clk_dir_q, cs0_dir_q;
    logic [2:0] mode_pins;
    logic [7:0] addr_hi, gpio_ctl_out, gpio_ctl_dir, portb_out, portb_dir, port1_out;
    logic [7:0] port1_dir, ext_pat, port1_pin_in, port4_pin_in, portb_pin_in, ctl_pin_in;
    logic [7:0] ctl_pin_out, ctl_pin_oe_n, portb_pin_out, portb_pin_oe_n, port1_pin_out;
    logic [7:0] port1_pin_oe_n, port1_data_in, pulse_timer_unit_in, converter_channel;
    logic [7:0] port4_data_in, portb_data_in, ctl_data_in;
    int         miscompares, samples_checked, cyc;
    pfm_mux uut (.*);
    pfm_pin_model model (.*);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // hang guard; whole run needs well under 1000 cycles
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic do_reset(input logic [2:0] m);
        @(posedge ref_clk);
        rst_n     <= 1'b0;
        mode_pins <= m;
        wt(5);
        chk("oe_in_reset", 8'hFF, ctl_pin_oe_n);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        wt(3);
    endtask
    task automatic wr_dir(input logic cs, input logic v);
        @(posedge ref_clk);
        clk_dir_wr  <= ~cs;
        cs0_dir_wr  <= cs;
        clk_dir_val <= v;
        cs0_dir_val <= v;
        @(posedge ref_clk);
        clk_dir_wr <= 1'b0;
        cs0_dir_wr <= 1'b0;
        wt(2);
    endtask
    task automatic t_modes();
        for (int m = 4; m < 8; m++) begin
            do_reset(m[2:0]);
            chk("clk_dir", {7'h0, m != 7}, {7'h0, clk_dir_q});
            chk("clk_oe", {7'h0, m == 7}, {7'h0, ctl_pin_oe_n[7]});
            if (m != 7) chk("cs0_dir", {7'h0, m != 6}, {7'h0, cs0_dir_q});
            chk("strobe_oe", (m == 7) ? 8'h07 : 8'h00, {5'h0, ctl_pin_oe_n[6:4]});
            if (m != 7) chk("strobe_out", 8'h05, {5'h0, ctl_pin_out[6:4]});
            chk("pb_out", (m == 7) ? portb_out : addr_hi, portb_pin_out);
            chk("pb_oe", (m == 7) ? ~portb_dir : 8'h00, portb_pin_oe_n);
        end
    endtask
    task automatic t_dirs();
        wr_dir(1'b0, 1'b1);
        chk("clk_on", {6'h0, 1'b0, sys_clk_en}, {6'h0, ctl_pin_oe_n[7], ctl_pin_out[7]});
        wr_dir(1'b0, 1'b0);
        chk("clk_off", 8'h01, {7'h0, ctl_pin_oe_n[7]});
        do_reset(3'h4);
        wr_dir(1'b1, 1'b0);
        chk("cs0_off", 8'h01, {7'h0, cs0_pin_oe_n});
        wr_dir(1'b1, 1'b1);
        chk("cs0_on", {7'h0, chip_select_0}, {cs0_pin_oe_n, 6'h0, cs0_pin_out});
    endtask
    task automatic t_inputs();
        @(posedge ref_clk);
        ext_pat   <= 8'h5B;
        port1_dir <= 8'hFF;
        wt(5);
        chk("p1_out", 8'h3C, port1_pin_out);
        chk("p1_oe", 8'h00, port1_pin_oe_n);
        @(posedge ref_clk);
        port1_dir <= 8'h00;
        wt(5);
        chk("conv_ch", 8'hA4, converter_channel);
        chk("p4_data", 8'hA4, port4_data_in);
        chk("p1_data", 8'h5B, port1_data_in);
        chk("timer_in", 8'h5B, pulse_timer_unit_in);
        chk("int01", 8'h03, {6'h0, ext_int_line_1, ext_int_line_0});
        chk("bus_request_in", 8'h03, {6'h0, bus_request_in, ext_int_line_2});
        chk("lwr16", {7'h0, low_byte_write_strobe}, {ctl_pin_oe_n[3], 6'h0, ctl_pin_out[3]});
        chk("int3_16", 8'h00, {6'h0, ext_int_line_3, conv_trigger_in});
        chk("pb_data", addr_hi, portb_data_in);
        @(posedge ref_clk);
        bus_16bit          <= 1'b0;
        bus_release_enable <= 1'b0;
        wt(5);
        chk("int3_8", 8'h07, {5'h0, ctl_pin_oe_n[3], ext_int_line_3, conv_trigger_in});
        chk("int2_io", 8'h01, {7'h0, ext_int_line_2});
        chk("bus_request_in_off", 8'h00, {7'h0, bus_request_in});
        chk("ctl_data", 8'hDB, ctl_data_in);
    endtask
    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {rst_n, clk_dir_wr, clk_dir_val, cs0_dir_wr, cs0_dir_val} = 5'h00;
        {bus_16bit, bus_release_enable, sys_clk_en, chip_select_0} = 4'hE;
        {address_strobe, read_strobe, high_byte_write_strobe} = 3'h5;
        low_byte_write_strobe = 1'b1;
        mode_pins    = 3'h4;
        addr_hi      = 8'hC3;
        gpio_ctl_out = 8'h96;
        gpio_ctl_dir = 8'h00;
        portb_out    = 8'h69;
        portb_dir    = 8'h0F;
        port1_out    = 8'h3C;
        port1_dir    = 8'h00;
        ext_pat      = 8'h00;
        miscompares  = 0;
        samples_checked = 0;
        cyc          = 0;
        t_modes();
        t_dirs();
        t_inputs();
        final_report();
    end
endmodule // tb_port_function_mux_by_mode

// >>> verilog/pfm_mux.sv
// Purpose: per-mode pin function selection for clock, strobe, select and ports
// Assumes: mode pins steady around reset; oe low means the pin is driven
// Notes:   mode sampled once after reset; outputs registered, one cycle late
// Operation
// - clock pin: input when direction 0, system clock out when 1; mode-based reset.
// - chip select 0 pin: driven when direction 1 in modes 4-6; resets 1 in modes 4 and 5, 0 otherwise.
// - port 1: general I/O plus timer capture/clock inputs and interrupt lines 0, 1.
// - port 4: input only, each pin also one converter channel.
// - port B: address A8-A15 in modes 4-6, plain I/O in mode 7.
// - low strobe pin: strobe in 16-bit bus in modes 4-6; else I/O plus interrupt 3 and trigger.
// - bus request pin: I/O until release enable set in modes 4-6, then request input; interrupt 2 kept.
`timescale 1ns/1ps
module pfm_mux (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // mode
    input  wire logic [2:0] mode_pins,
    input  wire logic       bus_16bit,
    input  wire logic       bus_release_enable,
    // direction controls
    input  wire logic       clk_dir_wr,
    input  wire logic       clk_dir_val,
    input  wire logic       cs0_dir_wr,
    input  wire logic       cs0_dir_val,
    // internal sources
    input  wire logic       sys_clk_en,
    input  wire logic       chip_select_0,
    input  wire logic       address_strobe,
    input  wire logic       read_strobe,
    input  wire logic       high_byte_write_strobe,
    input  wire logic       low_byte_write_strobe,
    input  wire logic [7:0] addr_hi,
    input  wire logic [7:0] gpio_ctl_out,
    input  wire logic [7:0] gpio_ctl_dir,
    input  wire logic [7:0] portb_out,
    input  wire logic [7:0] portb_dir,
    input  wire logic [7:0] port1_out,
    input  wire logic [7:0] port1_dir,
    // pins in
    input  wire logic [7:0] port1_pin_in,
    input  wire logic [7:0] port4_pin_in,
    input  wire logic [7:0] portb_pin_in,
    input  wire logic [7:0] ctl_pin_in,
    // pins out; bit 7 clock, 6 addr strobe, 5 read, 4 high wr, 3 low wr, 0 bus req
    output logic [7:0]      ctl_pin_out,
    output logic [7:0]      ctl_pin_oe_n,
    output logic            cs0_pin_out,
    output logic            cs0_pin_oe_n,
    output logic [7:0]      portb_pin_out,
    output logic [7:0]      portb_pin_oe_n,
    output logic [7:0]      port1_pin_out,
    output logic [7:0]      port1_pin_oe_n,
    // routed inputs
    output logic [7:0]      port1_data_in,
    output logic [7:0]      pulse_timer_unit_in,
    output logic            ext_int_line_0,
    output logic            ext_int_line_1,
    output logic            ext_int_line_2,
    output logic            ext_int_line_3,
    output logic            conv_trigger_in,
    output logic            bus_request_in,
    output logic [7:0]      converter_channel,
    output logic [7:0]      port4_data_in,
    output logic [7:0]      portb_data_in,
    output logic [7:0]      ctl_data_in,
    output logic            clk_dir_q,
    output logic            cs0_dir_q
);
    pfm_pkg::pfm_state_e st_q;
    logic [2:0] mode_q;
    logic [7:0] p1_s, p4_s, pb_s, ctl_s;
    logic [4*pfm_pkg::PORT_W-1:0] pins_s;
    logic [2:0] mode_meta_q, mode_s_q;
    logic       expanded;

    pfm_sync #(.W(4*pfm_pkg::PORT_W)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       ({port1_pin_in, port4_pin_in, portb_pin_in, ctl_pin_in}),
        .q       (pins_s)
    );

    assign {p1_s, p4_s, pb_s, ctl_s} = pins_s;

    // mode pins synchronised without reset so they settle while reset is held
    always_ff @(posedge ref_clk) begin
        mode_meta_q <= mode_pins;
        mode_s_q    <= mode_meta_q;
    end

    // mode caught after release, never under reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= pfm_pkg::PFM_ST_RESET;
            mode_q <= pfm_pkg::MODE_SINGLE;
        end else begin
            case (st_q)
                pfm_pkg::PFM_ST_RESET: st_q <= pfm_pkg::PFM_ST_LATCH;
                pfm_pkg::PFM_ST_LATCH: begin
                    mode_q <= mode_s_q;
                    st_q   <= pfm_pkg::PFM_ST_RUN;
                end
                pfm_pkg::PFM_ST_RUN:   st_q <= pfm_pkg::PFM_ST_RUN;
                default:               st_q <= pfm_pkg::PFM_ST_RESET;
            endcase
        end
    end

    assign expanded = (st_q == pfm_pkg::PFM_ST_RUN) && (mode_q != pfm_pkg::MODE_SINGLE);

    // direction bits: mode-dependent value loaded at latch; writes later
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_dir_q <= 1'b0;
            cs0_dir_q <= 1'b0;
        end else if (st_q == pfm_pkg::PFM_ST_LATCH) begin
            clk_dir_q <= (mode_s_q != pfm_pkg::MODE_SINGLE);
            cs0_dir_q <= (mode_s_q == pfm_pkg::MODE_EXP4) ||
                         (mode_s_q == pfm_pkg::MODE_EXP5);
        end else if (st_q == pfm_pkg::PFM_ST_RUN) begin
            if (clk_dir_wr)
                clk_dir_q <= clk_dir_val;
            if (cs0_dir_wr)
                cs0_dir_q <= cs0_dir_val;
        end
    end

    // control port pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_pin_out  <= pfm_pkg::BYTE_ZERO;
            ctl_pin_oe_n <= pfm_pkg::BYTE_ONES;
            cs0_pin_out  <= 1'b1;
            cs0_pin_oe_n <= 1'b1;
        end else begin
            for (int i = 0; i < pfm_pkg::PORT_W; i++) begin
                ctl_pin_out[i]  <= gpio_ctl_out[i];
                ctl_pin_oe_n[i] <= ~gpio_ctl_dir[i];
            end
            ctl_pin_out[pfm_pkg::BIT_CLK_PIN]  <= sys_clk_en;
            ctl_pin_oe_n[pfm_pkg::BIT_CLK_PIN] <= ~clk_dir_q;
            if (expanded) begin
                ctl_pin_out[pfm_pkg::BIT_ADDR_STB]  <= address_strobe;
                ctl_pin_out[pfm_pkg::BIT_READ_STB]  <= read_strobe;
                ctl_pin_out[pfm_pkg::BIT_HIGH_STB]  <= high_byte_write_strobe;
                ctl_pin_oe_n[pfm_pkg::BIT_ADDR_STB] <= 1'b0;
                ctl_pin_oe_n[pfm_pkg::BIT_READ_STB] <= 1'b0;
                ctl_pin_oe_n[pfm_pkg::BIT_HIGH_STB] <= 1'b0;
            end
            if (expanded && bus_16bit) begin
                ctl_pin_out[pfm_pkg::BIT_LOW_STB]  <= low_byte_write_strobe;
                ctl_pin_oe_n[pfm_pkg::BIT_LOW_STB] <= 1'b0;
            end
            if (expanded && bus_release_enable)
                ctl_pin_oe_n[pfm_pkg::BIT_REQ_PIN] <= 1'b1;
            cs0_pin_out  <= chip_select_0;
            cs0_pin_oe_n <= ~(expanded && cs0_dir_q);
        end
    end

    // port B and port 1 pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            portb_pin_out  <= pfm_pkg::BYTE_ZERO;
            portb_pin_oe_n <= pfm_pkg::BYTE_ONES;
            port1_pin_out  <= pfm_pkg::BYTE_ZERO;
            port1_pin_oe_n <= pfm_pkg::BYTE_ONES;
        end else begin
            portb_pin_out  <= expanded ? addr_hi : portb_out;
            portb_pin_oe_n <= expanded ? pfm_pkg::BYTE_ZERO : ~portb_dir;
            port1_pin_out  <= port1_out;
            port1_pin_oe_n <= ~port1_dir;
        end
    end

    // routed inputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port1_data_in       <= pfm_pkg::BYTE_ZERO;
            pulse_timer_unit_in <= pfm_pkg::BYTE_ZERO;
            ext_int_line_0      <= 1'b0;
            ext_int_line_1      <= 1'b0;
            ext_int_line_2      <= 1'b0;
            ext_int_line_3      <= 1'b0;
            conv_trigger_in     <= 1'b0;
            bus_request_in      <= 1'b0;
            converter_channel   <= pfm_pkg::BYTE_ZERO;
            port4_data_in       <= pfm_pkg::BYTE_ZERO;
            portb_data_in       <= pfm_pkg::BYTE_ZERO;
            ctl_data_in         <= pfm_pkg::BYTE_ZERO;
        end else begin
            port1_data_in       <= p1_s;
            pulse_timer_unit_in <= p1_s;
            ext_int_line_0      <= p1_s[pfm_pkg::BIT_INT0];
            ext_int_line_1      <= p1_s[pfm_pkg::BIT_INT1];
            converter_channel   <= p4_s;
            port4_data_in       <= p4_s;
            portb_data_in       <= pb_s;
            ctl_data_in         <= ctl_s;
            ext_int_line_2      <= ctl_s[pfm_pkg::BIT_REQ_PIN];
            bus_request_in      <= expanded && bus_release_enable && ctl_s[pfm_pkg::BIT_REQ_PIN];
            ext_int_line_3      <= !(expanded && bus_16bit) && ctl_s[pfm_pkg::BIT_LOW_STB];
            conv_trigger_in     <= !(expanded && bus_16bit) && ctl_s[pfm_pkg::BIT_LOW_STB];
        end
    end

    a_clk_pin_dir:
        assert property (@(posedge ref_clk) disable iff (!rst_n)
            ##1 ctl_pin_oe_n[pfm_pkg::BIT_CLK_PIN] == !$past(clk_dir_q))
        else $error("clock pin direction wrong");
    a_cs0_reset_val:
        assert property (@(posedge ref_clk) disable iff (!rst_n)
            st_q == pfm_pkg::PFM_ST_LATCH |=> cs0_dir_q ==
            ($past(mode_s_q) == pfm_pkg::MODE_EXP4 || $past(mode_s_q) == pfm_pkg::MODE_EXP5))
        else $error("select direction reset value wrong");
    a_int0_tap:
        assert property (@(posedge ref_clk) disable iff (!rst_n)
            ##1 ext_int_line_0 == $past(p1_s[pfm_pkg::BIT_INT0])) else $error("int0 tap wrong");
    a_port4_chan:
        assert property (@(posedge ref_clk) disable iff (!rst_n)
            ##1 converter_channel == $past(p4_s)) else $error("converter channel mismatch");
    a_portb_single:
        assert property (@(posedge ref_clk) disable iff (!rst_n)
            !expanded |=> portb_pin_oe_n == ~$past(portb_dir)) else $error("port B not plain");
    a_low_strobe:
        assert property (@(posedge ref_clk) disable iff (!rst_n)
            expanded && bus_16bit |=> !ctl_pin_oe_n[pfm_pkg::BIT_LOW_STB] && !conv_trigger_in)
        else $error("low strobe not driven");
    a_bus_req_gate:
        assert property (@(posedge ref_clk) disable iff (!rst_n)
            !bus_release_enable |=> !bus_request_in) else $error("request passed while disabled");
    a_strobe_drive:
        assert property (@(posedge ref_clk) disable iff (!rst_n)
            expanded |=> ctl_pin_oe_n[pfm_pkg::BIT_ADDR_STB:pfm_pkg::BIT_HIGH_STB] == 3'h0)
        else $error("bus strobes not driven");
endmodule // pfm_mux

// >>> verilog/pfm_pkg.sv
// Purpose: constants for the mode-dependent port function mux
// Assumes: mode code latched from mode pins after reset release
// Notes:   single clock, no register bus
package pfm_pkg;
    localparam logic [2:0] MODE_EXP4   = 3'h4;
    localparam logic [2:0] MODE_EXP5   = 3'h5;
    localparam logic [2:0] MODE_EXP6   = 3'h6;
    localparam logic [2:0] MODE_SINGLE = 3'h7;
    localparam int         PORT_W      = 8;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic [7:0] BYTE_ONES   = 8'hFF;
    localparam int         BIT_INT0    = 4;
    localparam int         BIT_INT1    = 6;
    localparam int         BIT_CLK_PIN  = 7;
    localparam int         BIT_ADDR_STB = 6;
    localparam int         BIT_READ_STB = 5;
    localparam int         BIT_HIGH_STB = 4;
    localparam int         BIT_LOW_STB  = 3;
    localparam int         BIT_REQ_PIN  = 0;
    typedef enum logic [1:0] {
        PFM_ST_RESET = 2'h0,
        PFM_ST_LATCH = 2'h1,
        PFM_ST_RUN   = 2'h3
    } pfm_state_e;
endpackage

// >>> verilog/pfm_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: asynchronous sources
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module pfm_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // pfm_sync
